/* File: bench/test_speech_frame_bit_packer.sv */
`timescale 1ns/100ps
module test_speech_frame_bit_packer;
  import speech_frame_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [PCM_W-1:0] pcm_i = '0;
  logic pcm_valid_i = 1'b0, recon_valid_i = 1'b0, lar_valid_i = 1'b0, sub_valid_i = 1'b0;
  logic [LAR_BITS-1:0] lar_i = '0;
  logic [LAG_W-1:0] lag_i = '0;
  logic [GAIN_W-1:0] gain_i = '0;
  logic [GRID_W-1:0] grid_i = '0;
  logic [AMP_W-1:0] amp_i = '0;
  logic [PULSES_W-1:0] pulses_i = '0;
  logic rx_bit_i = 1'b0, rx_start_i = 1'b0, rx_valid_i = 1'b0, tx_ready_i;
  logic stall = 1'b0, clr = 1'b0;
  logic [PCM_W-1:0] sample_o;
  logic [5:0] sample_idx_o;
  logic [1:0] subframe_o, rx_sub_idx_o;
  logic ltp_update_o, frame_done_o, frame_late_o, recon_done_o, hist_full_o, param_ready_o;
  logic tx_bit_o, tx_start_o, tx_valid_o, rx_frame_valid_o, rx_sync_err_o, rx_sub_valid_o;
  logic [LAR_BITS-1:0] rx_lar_o;
  logic [LAG_W-1:0] rx_lag_o;
  logic [GAIN_W-1:0] rx_gain_o;
  logic [GRID_W-1:0] rx_grid_o;
  logic [AMP_W-1:0] rx_amp_o;
  logic [PULSES_W-1:0] rx_pulses_o;
  logic [259:0] got_bits, got_starts;
  logic [8:0] got_cnt;
  int n_errors = 0;
  int checks_done = 0;
  int pos = 0;
  logic [35:0] lar_w = 36'h5C3A961EB;
  logic [55:0] sub_w [4] = '{56'hD13B5E72A4C6F9, 56'h2E84C1B7F0935A, 56'h7F0A13C5E9B64D, 56'hA6592DE0C37F18};
  wire [259:0] frame_exp = {sub_w[3], sub_w[2], sub_w[1], sub_w[0], lar_w};

  speech_frame_bit_packer #(.FRAME_CYC(500)) dut (.clk_sys_i, .rst_n_i, .pcm_i, .pcm_valid_i,
    .sample_o, .sample_idx_o, .subframe_o, .ltp_update_o, .frame_done_o, .frame_late_o,
    .recon_valid_i, .recon_done_o, .hist_full_o, .lar_i, .lar_valid_i, .lag_i, .gain_i,
    .grid_i, .amp_i, .pulses_i, .sub_valid_i, .param_ready_o, .tx_bit_o, .tx_start_o,
    .tx_valid_o, .tx_ready_i, .rx_bit_i, .rx_start_i, .rx_valid_i, .rx_frame_valid_o,
    .rx_sync_err_o, .rx_lar_o, .rx_lag_o, .rx_gain_o, .rx_grid_o, .rx_amp_o, .rx_pulses_o,
    .rx_sub_idx_o, .rx_sub_valid_o);

  tx_sink_model sink (.clk_sys_i, .rst_n_i, .bit_i(tx_bit_o), .start_i(tx_start_o),
    .valid_i(tx_valid_o), .stall_i(stall), .clr_i(clr), .ready_o(tx_ready_i),
    .bits_o(got_bits), .starts_o(got_starts), .cnt_o(got_cnt));

  always #50 clk_sys_i = ~clk_sys_i;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic step();
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic chk(input string nm, input logic [259:0] e, input logic [259:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic run_samples(input int n);
    for (int i = 0; i < n; i++) begin
      pcm_i = 13'h1F00 + 13'(i);
      pcm_valid_i = 1'b1;
      step();
      chk("sample", 260'(pcm_i), 260'(sample_o));
      chk("sample_idx", 260'((pos + 1) % 40), 260'(sample_idx_o));
      chk("subframe", 260'(((pos + 1) / 40) % 4), 260'(subframe_o));
      chk("ltp_update", 260'(pos % 40 == 0), 260'(ltp_update_o));
      chk("frame_done", 260'(pos == 159), 260'(frame_done_o));
      pos = (pos + 1) % 160;
    end
    pcm_valid_i = 1'b0;
    // idle cycle so a following call never re-raises valid in this time step
    step();
  endtask

  task automatic late_frame();
    run_samples(1);
    repeat (490) step();
    chk("late_early", 260'(0), 260'(frame_late_o));
    repeat (15) step();
    chk("late_set", 260'(1), 260'(frame_late_o));
    run_samples(159);
    run_samples(1);
    chk("late_clear", 260'(0), 260'(frame_late_o));
    run_samples(159);
  endtask

  task automatic recon_run();
    for (int i = 0; i < 120; i++) begin
      recon_valid_i = 1'b1;
      step();
      chk("recon_done", 260'(i % 40 == 39), 260'(recon_done_o));
      chk("hist_full", 260'(i >= 119), 260'(hist_full_o));
    end
    recon_valid_i = 1'b0;
  endtask

  task automatic tx_frame(input logic stl);
    int w;
    stall = stl;
    clr = 1'b1;
    step();
    clr = 1'b0;
    for (w = 0; w < 400 && param_ready_o !== 1'b1; w++) step();
    // stalled frame carries inverted data, so stale frame bits cannot pass
    lar_i = lar_w ^ {36{stl}};
    lar_valid_i = 1'b1;
    step();
    lar_valid_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      {pulses_i, amp_i, grid_i, gain_i, lag_i} = sub_w[k] ^ {56{stl}};
      sub_valid_i = 1'b1;
      step();
    end
    sub_valid_i = 1'b0;
    step();
    step();
    chk("ready_busy", 260'(0), 260'(param_ready_o));
    for (w = 0; w < 2000 && got_cnt !== 9'h104; w++) step();
    chk("tx_bits", frame_exp ^ {260{stl}}, got_bits);
    chk("tx_starts", 260'(1), got_starts);
    for (w = 0; w < 20 && param_ready_o !== 1'b1; w++) step();
    chk("ready_back", 260'(1), 260'(param_ready_o));
    chk("tx_count", 260'(260), 260'(got_cnt));
  endtask

  task automatic rx_frame(input int pre);
    int nfv;
    int nsub;
    nfv = 0;
    nsub = 0;
    for (int i = 0; i < pre + 260; i++) begin
      // a gap now and then: the qualifier, not the clock, paces bits
      if (i % 7 == 3) begin
        rx_valid_i = 1'b0;
        step();
      end
      rx_valid_i = 1'b1;
      rx_start_i = (i == 0) || (i == pre);
      rx_bit_i = (i < pre) ? ~frame_exp[i] : frame_exp[i - pre];
      step();
      if (i == pre) chk("sync_err", 260'(pre > 0), 260'(rx_sync_err_o));
    end
    rx_valid_i = 1'b0;
    rx_start_i = 1'b0;
    for (int c = 0; c < 9; c++) begin
      if (rx_frame_valid_o === 1'b1) begin
        nfv++;
        chk("rx_lar", 260'(lar_w), 260'(rx_lar_o));
      end
      if (rx_sub_valid_o === 1'b1) begin
        chk("rx_sub_idx", 260'(nsub), 260'(rx_sub_idx_o));
        chk("rx_fields", 260'(sub_w[nsub & 3]),
            260'({rx_pulses_o, rx_amp_o, rx_grid_o, rx_gain_o, rx_lag_o}));
        nsub++;
      end
      step();
    end
    chk("rx_frames", 260'(1), 260'(nfv));
    chk("rx_subs", 260'(4), 260'(nsub));
  endtask

  // --------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys_i);
    chk("reset_outs", 260'(0), 260'({param_ready_o, tx_valid_o, frame_done_o}));
    #1;
    rst_n_i = 1'b1;
    step();
    step();
    run_samples(160);
    late_frame();
    recon_run();
    tx_frame(1'b1);
    tx_frame(1'b0);
    rx_frame(0);
    rx_frame(100);
    give_verdict();
  end

  // whole run is near 3200 cycles; six times that means a hang
  initial begin
    #2_000_000;
    n_errors++;
    give_verdict();
  end
endmodule

/* File: bench/tx_sink_model.sv */
`timescale 1ns/100ps
// --------------------------------------------------------------
// far-side consumer of the bit stream
// --------------------------------------------------------------
module tx_sink_model (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic bit_i,
  input wire logic start_i,
  input wire logic valid_i,
  input wire logic stall_i,
  input wire logic clr_i,
  output logic ready_o,
  output logic [259:0] bits_o,
  output logic [259:0] starts_o,
  output logic [8:0] cnt_o
);
  logic [1:0] ph_reg;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_reg <= 2'h0;
      ready_o <= 1'b0;
      cnt_o <= 9'h000;
      bits_o <= '0;
      starts_o <= '0;
    end else begin
      ph_reg <= ph_reg + 2'h1;
      // stalling: one ready cycle in four keeps the buffer full
      ready_o <= !stall_i || (ph_reg == 2'h3);
      if (clr_i) begin
        cnt_o <= 9'h000;
      end else if (valid_i && ready_o && cnt_o < 9'h104) begin
        bits_o[cnt_o] <= bit_i;
        starts_o[cnt_o] <= start_i;
        cnt_o <= cnt_o + 9'h001;
      end
    end
  end
endmodule

/* File: verilog/bit_stream_if.sv */
`timescale 1ns/100ps
interface bit_stream_if #(parameter int WIDTH = 2);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: verilog/frame_bit_buffer.sv */
`timescale 1ns/100ps
module frame_bit_buffer #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  bit_stream_if.snk in_s,
  bit_stream_if.src out_s
);
  // ----------------------------------------------------------------
  // head register plus one skid entry
  // ----------------------------------------------------------------
  if (DEPTH != 2) begin : g_depth_chk
    $error("frame_bit_buffer serves DEPTH 2 only");
  end

  logic head_v_reg, head_v_next, skid_v_reg, skid_v_next;
  logic [WIDTH-1:0] head_d_reg, head_d_next, skid_d_reg, skid_d_next;
  wire push = in_s.valid & in_s.ready;
  wire pop = head_v_reg & out_s.ready;
  wire head_load = ~head_v_reg | pop;

  // ready only looks at the skid flop, so no path from out ready to in ready
  assign in_s.ready = ~skid_v_reg;
  assign head_v_next = head_load ? (skid_v_reg | push) : 1'b1;
  assign head_d_next = head_load ? (skid_v_reg ? skid_d_reg : in_s.data) : head_d_reg;
  assign skid_v_next = ~head_load & (skid_v_reg | push);
  assign skid_d_next = (push & ~head_load) ? in_s.data : skid_d_reg;
  assign out_s.valid = head_v_reg;
  assign out_s.data = head_d_reg;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      head_v_reg <= 1'b0;
      skid_v_reg <= 1'b0;
      head_d_reg <= '0;
      skid_d_reg <= '0;
    end else begin
      head_v_reg <= head_v_next;
      skid_v_reg <= skid_v_next;
      head_d_reg <= head_d_next;
      skid_d_reg <= skid_d_next;
    end
  end

  a_buf_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    out_s.valid && !out_s.ready |=> out_s.valid && $stable(out_s.data))
    else $error("buffer head changed while stalled");
endmodule

/* File: verilog/speech_frame_bit_packer.sv */
`timescale 1ns/100ps
// Functional notes
// - accept 160-sample frames of 13-bit pcm, one coded frame each.
// - split frame into 4 sub-frames of 40 samples, in time order.
// - update lag and gain before each sub-frame, using 120-sample history.
// - per sub-frame, choose one of 4 pulse grids, sent as grid position.
// - carry block amplitude as side information beside the 13 pulses.
// - count locally decoded 40 residual samples per sub-frame for feedback.
// - receive side hands sub-frame parameters to the same reconstruction loop.
// - transmit and receive use one identical bit order, first to last.
// - exactly 260 bits per frame, one frame per 20 ms period.
// - filter coefficients bits 1-36, then sub-frames 1 to 4.
// - lsb at lowest bit; coefficient widths 6,6,5,5,4,4,3,3.
// - lag 7 bits then gain 2 bits open each sub-frame.
// - grid position 2 bits, then block amplitude 6 bits.
// - thirteen 3-bit pulse codes follow; sub-frame spans 56 bits.
module speech_frame_bit_packer
  import speech_frame_pkg::*;
#(
  parameter int FRAME_CYC = FRAME_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [PCM_W-1:0] pcm_i,
  input wire logic pcm_valid_i,
  output logic [PCM_W-1:0] sample_o,
  output logic [5:0] sample_idx_o,
  output logic [1:0] subframe_o,
  output logic ltp_update_o,
  output logic frame_done_o,
  output logic frame_late_o,
  input wire logic recon_valid_i,
  output logic recon_done_o,
  output logic hist_full_o,
  input wire logic [LAR_BITS-1:0] lar_i,
  input wire logic lar_valid_i,
  input wire logic [LAG_W-1:0] lag_i,
  input wire logic [GAIN_W-1:0] gain_i,
  input wire logic [GRID_W-1:0] grid_i,
  input wire logic [AMP_W-1:0] amp_i,
  input wire logic [PULSES_W-1:0] pulses_i,
  input wire logic sub_valid_i,
  output logic param_ready_o,
  output logic tx_bit_o,
  output logic tx_start_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic rx_bit_i,
  input wire logic rx_start_i,
  input wire logic rx_valid_i,
  output logic rx_frame_valid_o,
  output logic rx_sync_err_o,
  output logic [LAR_BITS-1:0] rx_lar_o,
  output logic [LAG_W-1:0] rx_lag_o,
  output logic [GAIN_W-1:0] rx_gain_o,
  output logic [GRID_W-1:0] rx_grid_o,
  output logic [AMP_W-1:0] rx_amp_o,
  output logic [PULSES_W-1:0] rx_pulses_o,
  output logic [1:0] rx_sub_idx_o,
  output logic rx_sub_valid_o
);
  localparam int TMR_W = $clog2(FRAME_CYC + 1);

  if (FRAME_CYC < 1) begin : g_cyc_chk
    $error("FRAME_CYC must be at least one");
  end
  if (lar_width_sum() != LAR_BITS ||
      PULSE_OFS + PULSES * PULSE_W != SUB_BITS ||
      SUB_BASE + SUBFRAMES * SUB_BITS != FRAME_BITS) begin : g_layout_chk
    $error("frame layout does not add up");
  end

  function automatic logic [SUB_BITS-1:0] pack_sub(
    input logic [LAG_W-1:0] lag, input logic [GAIN_W-1:0] gain,
    input logic [GRID_W-1:0] grid, input logic [AMP_W-1:0] amp,
    input logic [PULSES_W-1:0] pulses);
    return {pulses, amp, grid, gain, lag};
  endfunction

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // sample and sub-frame sequencing
  // ----------------------------------------------------------------
  logic [5:0] smp_reg;
  logic [1:0] sub_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic in_frame_reg, late_reg, upd_reg, done_reg;
  logic [PCM_W-1:0] sample_reg;
  wire last_smp = smp_reg == 6'(SUB_SAMPLES - 1);
  wire last_sub = sub_reg == 2'(SUBFRAMES - 1);
  wire frame_end = pcm_valid_i & last_smp & last_sub;
  wire frame_first = pcm_valid_i & (smp_reg == 6'h00) & (sub_reg == 2'h0);
  wire tmr_hit = in_frame_reg & (tmr_reg == TMR_W'(FRAME_CYC - 1));

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smp_reg <= 6'h00;
      sub_reg <= 2'h0;
      sample_reg <= '0;
      upd_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      upd_reg <= pcm_valid_i & (smp_reg == 6'h00);
      done_reg <= frame_end;
      if (pcm_valid_i) begin
        sample_reg <= pcm_i;
        smp_reg <= last_smp ? 6'h00 : smp_reg + 6'h01;
        sub_reg <= last_smp ? sub_reg + 2'h1 : sub_reg;
      end
    end
  end

  // late when a frame of samples does not complete inside one frame period
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tmr_reg <= '0;
      in_frame_reg <= 1'b0;
      late_reg <= 1'b0;
    end else begin
      tmr_reg <= frame_first ? '0 : (in_frame_reg ? tmr_reg + TMR_W'(1) : tmr_reg);
      in_frame_reg <= frame_first | (in_frame_reg & ~frame_end & ~tmr_hit);
      late_reg <= tmr_hit | (late_reg & ~frame_first);
    end
  end

  // ----------------------------------------------------------------
  // reconstruction history
  // ----------------------------------------------------------------
  logic [HIST_W-1:0] hist_reg;
  logic [5:0] rcn_reg;
  logic rcn_done_reg, hist_full_reg;
  wire rcn_last = rcn_reg == 6'(SUB_SAMPLES - 1);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hist_reg <= '0;
      rcn_reg <= 6'h00;
      rcn_done_reg <= 1'b0;
      hist_full_reg <= 1'b0;
    end else begin
      rcn_done_reg <= recon_valid_i & rcn_last;
      // flag registered so the output needs no decode after the flop
      hist_full_reg <= hist_full_reg | (recon_valid_i & (hist_reg == HIST_W'(LTP_HIST - 1)));
      if (recon_valid_i) begin
        rcn_reg <= rcn_last ? 6'h00 : rcn_reg + 6'h01;
        if (hist_reg != HIST_W'(LTP_HIST)) begin
          hist_reg <= hist_reg + HIST_W'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // frame assembly and serialisation
  // ----------------------------------------------------------------
  tx_state_t state_reg, state_next;
  logic [FRAME_BITS-1:0] frame_reg;
  logic [BIT_IDX_W-1:0] send_reg;
  logic [2:0] sub_cnt_reg;
  logic lar_have_reg, ready_reg;
  bit_stream_if #(.WIDTH(TX_WORD_W)) buf_in ();
  bit_stream_if #(.WIDTH(TX_WORD_W)) buf_out ();
  wire lar_take = lar_valid_i & ready_reg & ~lar_have_reg;
  wire sub_take = sub_valid_i & ready_reg & lar_have_reg;
  wire push = buf_in.valid & buf_in.ready;
  wire send_last = send_reg == BIT_IDX_W'(FRAME_BITS - 1);
  wire [SUB_BITS-1:0] sub_word = pack_sub(lag_i, gain_i, grid_i, amp_i, pulses_i);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ASSEMBLE: if (sub_take && sub_cnt_reg == 3'(SUBFRAMES - 1)) state_next = SEND;
      SEND: if (push && send_last) state_next = ASSEMBLE;
    endcase
  end

  // first bit of each frame carries the start mark into the buffer
  assign buf_in.valid = state_reg == SEND;
  assign buf_in.data = {send_reg == '0, frame_reg[send_reg]};
  assign buf_out.ready = tx_ready_i;
  assign tx_valid_o = buf_out.valid;
  assign tx_bit_o = buf_out.data[TX_BIT_POS];
  assign tx_start_o = buf_out.data[TX_START_POS];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ASSEMBLE;
      ready_reg <= 1'b0;
      lar_have_reg <= 1'b0;
      sub_cnt_reg <= 3'h0;
      send_reg <= '0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == ASSEMBLE);
      lar_have_reg <= (lar_have_reg | lar_take) & ~(state_next == SEND);
      sub_cnt_reg <= (state_next == SEND) ? 3'h0 : sub_cnt_reg + 3'(sub_take);
      send_reg <= push ? (send_last ? '0 : send_reg + BIT_IDX_W'(1)) : send_reg;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_reg <= '0;
    end else if (lar_take) begin
      frame_reg[LAR_BITS-1:0] <= lar_i;
    end else if (sub_take) begin
      frame_reg[SUB_BASE + SUB_BITS * sub_cnt_reg +: SUB_BITS] <= sub_word;
    end
  end

  frame_bit_buffer #(.WIDTH(TX_WORD_W), .DEPTH(2)) u_buf (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_s(buf_in),
    .out_s(buf_out)
  );

  // ----------------------------------------------------------------
  // receive side: collect 260 bits, then hand out sub-frames
  // ----------------------------------------------------------------
  logic [FRAME_BITS-1:0] rx_frame_reg, rx_hold_reg;
  logic [BIT_IDX_W-1:0] rx_idx_reg;
  logic [2:0] emit_reg;
  logic rx_act_reg, rx_fv_reg, rx_err_reg, rx_sv_reg;
  logic [SUB_BITS-1:0] rx_sub_reg;
  logic [1:0] rx_si_reg;
  logic [LAR_BITS-1:0] rx_lar_reg;
  wire [BIT_IDX_W-1:0] rx_wr_idx = rx_start_i ? '0 : rx_idx_reg;
  wire rx_take = rx_valid_i & (rx_start_i | rx_act_reg);
  wire rx_last = rx_take & (rx_wr_idx == BIT_IDX_W'(FRAME_BITS - 1));
  wire emitting = emit_reg != 3'(SUBFRAMES);
  wire [SUB_BITS-1:0] rx_slice = rx_hold_reg[SUB_BASE + SUB_BITS * emit_reg +: SUB_BITS];

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_frame_reg <= '0;
      rx_idx_reg <= '0;
      rx_act_reg <= 1'b0;
      rx_err_reg <= 1'b0;
      rx_fv_reg <= 1'b0;
    end else begin
      rx_fv_reg <= rx_last;
      rx_err_reg <= rx_valid_i & rx_start_i & rx_act_reg;
      if (rx_take) begin
        rx_frame_reg[rx_wr_idx] <= rx_bit_i;
        rx_idx_reg <= rx_wr_idx + BIT_IDX_W'(1);
        rx_act_reg <= ~rx_last;
      end
    end
  end

  // a full frame is copied so the next one can stream in while we emit
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_hold_reg <= '0;
      emit_reg <= 3'(SUBFRAMES);
      rx_lar_reg <= '0;
      rx_sub_reg <= '0;
      rx_si_reg <= 2'h0;
      rx_sv_reg <= 1'b0;
    end else begin
      rx_sv_reg <= emitting & ~rx_last;
      rx_si_reg <= emit_reg[1:0];
      if (emitting) rx_sub_reg <= rx_slice;
      if (rx_last) begin
        rx_hold_reg <= {rx_bit_i, rx_frame_reg[FRAME_BITS-2:0]};
        rx_lar_reg <= rx_frame_reg[LAR_BITS-1:0];
        emit_reg <= 3'h0;
      end else if (emitting) begin
        emit_reg <= emit_reg + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sample_o = sample_reg;
  assign sample_idx_o = smp_reg;
  assign subframe_o = sub_reg;
  assign ltp_update_o = upd_reg;
  assign frame_done_o = done_reg;
  assign frame_late_o = late_reg;
  assign recon_done_o = rcn_done_reg;
  assign hist_full_o = hist_full_reg;
  assign param_ready_o = ready_reg;
  assign rx_frame_valid_o = rx_fv_reg;
  assign rx_sync_err_o = rx_err_reg;
  assign rx_lar_o = rx_lar_reg;
  assign rx_lag_o = rx_sub_reg[LAG_OFS +: LAG_W];
  assign rx_gain_o = rx_sub_reg[GAIN_OFS +: GAIN_W];
  assign rx_grid_o = rx_sub_reg[GRID_OFS +: GRID_W];
  assign rx_amp_o = rx_sub_reg[AMP_OFS +: AMP_W];
  assign rx_pulses_o = rx_sub_reg[PULSE_OFS +: PULSES_W];
  assign rx_sub_idx_o = rx_si_reg;
  assign rx_sub_valid_o = rx_sv_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_frame_wrap: assert property (
    frame_done_o |-> sample_idx_o == 6'h00 && subframe_o == 2'h0)
    else $error("frame end did not wrap counters");
  a_sub_order: assert property (
    pcm_valid_i && last_smp |=> subframe_o == $past(subframe_o) + 2'h1)
    else $error("sub-frame did not advance");
  a_ltp_update: assert property (
    ltp_update_o |-> sample_idx_o == 6'h01 && $past(pcm_valid_i))
    else $error("lag update not at sub-frame start");
  a_hist_bound: assert property (
    hist_reg <= HIST_W'(LTP_HIST))
    else $error("history count beyond limit");
  a_recon_count: assert property (
    recon_done_o |-> $past(rcn_reg) == 6'(SUB_SAMPLES - 1) && rcn_reg == 6'h00)
    else $error("recon block not 40 samples");
  a_start_first: assert property (
    tx_valid_o && tx_ready_i && tx_start_o |=> !tx_start_o || !tx_valid_o)
    else $error("start mark not on first bit");
  a_send_length: assert property (
    state_reg == SEND ##1 state_reg == ASSEMBLE |-> $past(send_reg) == 9'h103)
    else $error("frame not 260 bits");
  a_lag_place: assert property (
    sub_take |=> frame_reg[SUB_BASE + SUB_BITS * $past(sub_cnt_reg) +: LAG_W] == $past(lag_i))
    else $error("lag not at sub-frame start");
  a_rx_emit: assert property (
    rx_frame_valid_o |-> ##[1:2] rx_sub_valid_o && rx_sub_idx_o == 2'h0)
    else $error("received frame not handed out");

  c_frame_sent: cover property (state_reg == SEND ##1 state_reg == ASSEMBLE);
  c_stall: cover property ((tx_valid_o && !tx_ready_i) [*3]);
  c_rx_frame: cover property (rx_sub_valid_o && rx_sub_idx_o == 2'h3);
  c_late: cover property ($rose(frame_late_o));
endmodule

/* File: verilog/speech_frame_pkg.sv */
package speech_frame_pkg;
  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 260;
  localparam int BIT_IDX_W = 9;
  localparam int SAMPLES_PER_FRAME = 160;
  localparam int SUBFRAMES = 4;
  localparam int SUB_SAMPLES = 40;
  localparam int PCM_W = 13;
  localparam int LTP_HIST = 120;
  localparam int HIST_W = 7;
  // ----------------------------------------------------------------
  // field layout, lsb at lowest bit number
  // ----------------------------------------------------------------
  localparam int NUM_LAR = 8;
  localparam int LAR_W [NUM_LAR] = '{6, 6, 5, 5, 4, 4, 3, 3};
  localparam int LAR_BITS = 36;
  localparam int SUB_BASE = 36;
  localparam int SUB_BITS = 56;
  localparam int LAG_W = 7;
  localparam int GAIN_W = 2;
  localparam int GRID_W = 2;
  localparam int AMP_W = 6;
  localparam int PULSES = 13;
  localparam int PULSE_W = 3;
  localparam int PULSES_W = 39;
  localparam int LAG_OFS = 0;
  localparam int GAIN_OFS = 7;
  localparam int GRID_OFS = 9;
  localparam int AMP_OFS = 11;
  localparam int PULSE_OFS = 17;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int FRAME_PERIOD_MS = 20;
  localparam int SAMPLE_RATE_HZ = 8000;
  localparam int FRAME_CYCLES = FRAME_PERIOD_MS * (CLK_HZ / 1000);
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
  // ----------------------------------------------------------------
  // buffer word: {frame_start, bit}
  // ----------------------------------------------------------------
  localparam int TX_WORD_W = 2;
  localparam int TX_START_POS = 1;
  localparam int TX_BIT_POS = 0;

  typedef enum logic [0:0] {ASSEMBLE, SEND} tx_state_t;

  function automatic int lar_width_sum();
    int s;
    s = 0;
    for (int i = 0; i < NUM_LAR; i++) begin
      s = s + LAR_W[i];
    end
    return s;
  endfunction
endpackage
